// File: inc/oetc_pkg.sv
/*
 * oetc_pkg: constants and carriers for the oscillator enable and
 * temperature-coefficient trim control block.
 * Assumes a byte-wide register port with one-cycle read latency.
 */
package oetc_pkg;

    // ------------------------------------------------------------
    // register indices (byte port addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_OSC_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_OSC_CTRL2  = 4'h1;
    localparam logic [3:0] ADDR_CONFIG_WRITE_GUARD       = 4'h2;
    localparam logic [3:0] ADDR_CLK_SEL    = 4'h3;
    localparam logic [3:0] ADDR_TRIM_HI    = 4'h4;
    localparam logic [3:0] ADDR_STATUS     = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OSC_EN_BIT      = 7;
    localparam int MON_RST_EN_BIT  = 1;
    localparam int AMP_MODE_BIT    = 0;
    localparam int PLL_SEL_BIT     = 6;
    localparam int TC_TRIM_LSB     = 3;
    localparam int TC_TRIM_W       = 5;
    localparam int STAT_LOCK_BIT   = 3;
    localparam int STAT_UP_BIT     = 2;
    localparam int IRQ_LOSS_BIT    = 1;
    localparam int IRQ_UP_BIT      = 0;

    // ------------------------------------------------------------
    // values and resets
    // ------------------------------------------------------------
    localparam logic [7:0] CONFIG_WRITE_GUARD_UNLOCK_KEY = 8'h26;
    localparam logic [7:0] OSC_CTRL_RST    = 8'h00;
    localparam logic [1:0] OSC_CTRL2_RST   = 2'h0;
    localparam logic       CONFIG_WRITE_GUARD_RST        = 1'b0;
    localparam logic       PLL_SEL_RST     = 1'b1;
    localparam logic [4:0] TC_TRIM_RST     = 5'h00;
    localparam logic [1:0] IRQ_RST         = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int UP_QUAL_NS      = 40000;
    localparam int UP_QUAL_CYC     = (UP_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } oetc_bus_s;

    typedef struct packed {
        logic       osc_run;
        logic       monitor_on;
        logic       ref_from_osc;
        logic       pins_claimed;
        logic       amp_full_swing;
    } oetc_osc_ctl_s;

endpackage

// File: rtl/oetc_tc_decode.sv
/*
 * oetc_tc_decode: turns the 5-bit temperature-coefficient trim code
 * into the enable, direction and magnitude fed to the compensation circuit.
 * Assumes a purely combinational consumer.
 */
`timescale 1ns/10ps
module oetc_tc_decode
    import oetc_pkg::*;
#(
    parameter int W = TC_TRIM_W
) (
    input  wire logic [W-1:0] tc_code,
    output logic              tc_comp_en,
    output logic              tc_positive,
    output logic [W-2:0]      tc_magnitude
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        tc_positive  = tc_code[W-1];
        tc_magnitude = tc_code[W-2:0];
        tc_comp_en   = (tc_code[W-2:0] != '0);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_tc_off;
        @(tc_code) (tc_code[W-2:0] == '0) |-> !tc_comp_en;
    endproperty
    a_tc_off: assert property (p_tc_off) else $error("tc compensation on at nominal code");
endmodule // oetc_tc_decode

// File: rtl/oetc_ctrl.sv
/*
 * oetc_ctrl: oscillator control registers, protection gate, stable flag
 * qualification, crystal pin claim and trim decoding.
 * Assumes synchronous inputs on one 100 MHz clock and a byte register port.
 */
`timescale 1ns/10ps
module oetc_ctrl
    import oetc_pkg::*;
#(
    parameter int QUAL_CYC = UP_QUAL_CYC
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic [7:0]      rdata,
    input  wire logic       pll_locked_in,
    input  wire logic       osc_clock_seen,
    input  wire logic       osc_src_req,
    output oetc_osc_ctl_s   osc_ctl,
    output logic            osc_src_allowed,
    output logic            osc_monitor_reset,
    output logic            tc_comp_en,
    output logic            tc_positive,
    output logic [3:0]      tc_magnitude,
    output logic            irq
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic srst_n = rst_sync_reg;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    oetc_bus_s  bus;
    logic       osc_en_reg,   osc_en_next;
    logic       mon_en_reg,   mon_en_next;
    logic       amp_reg,      amp_next;
    logic       guard_reg,    guard_next;
    logic       pll_sel_reg,  pll_sel_next;
    logic [4:0] tc_reg,       tc_next;
    logic       pins_reg,     pins_next;
    logic       lock_reg,     lock_next;
    logic       up_reg,       up_next;
    logic [1:0] ist_reg,      ist_next;
    logic [1:0] imask_reg,    imask_next;
    logic [7:0] rdata_reg,    rdata_next;
    logic [$clog2(QUAL_CYC+1)-1:0] qcnt_reg, qcnt_next;
    logic       osc_wr;
    logic       loss_evt;
    logic       up_evt;

    assign bus = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wdata};

    function automatic logic hit(input oetc_bus_s b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    always_comb begin
        osc_wr       = hit(bus, ADDR_OSC_CTRL) && !guard_reg && pll_sel_reg;
        osc_en_next  = osc_en_reg;
        mon_en_next  = mon_en_reg;
        amp_next     = amp_reg;
        guard_next   = guard_reg;
        pll_sel_next = pll_sel_reg;
        tc_next      = tc_reg;
        pins_next    = pins_reg;
        imask_next   = imask_reg;
        if (osc_wr) begin
            osc_en_next = bus.wdata[OSC_EN_BIT];
            if (bus.wdata[OSC_EN_BIT])
                pins_next = 1'b1;
        end
        // osc_ctrl2 uses the main control byte's gating and is also locked while the oscillator is enabled
        if (hit(bus, ADDR_OSC_CTRL2) && !guard_reg && pll_sel_reg && !osc_en_reg) begin
            mon_en_next = bus.wdata[MON_RST_EN_BIT];
            amp_next    = bus.wdata[AMP_MODE_BIT];
        end
        if (hit(bus, ADDR_CONFIG_WRITE_GUARD))
            guard_next = (bus.wdata != CONFIG_WRITE_GUARD_UNLOCK_KEY);
        if (hit(bus, ADDR_CLK_SEL) && !guard_reg)
            pll_sel_next = bus.wdata[PLL_SEL_BIT];
        if (hit(bus, ADDR_TRIM_HI) && !guard_reg)
            tc_next = bus.wdata[TC_TRIM_LSB +: TC_TRIM_W];
        if (hit(bus, ADDR_IRQ_MASK))
            imask_next = bus.wdata[1:0];
    end

    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            osc_en_reg  <= OSC_CTRL_RST[OSC_EN_BIT];
            mon_en_reg  <= OSC_CTRL2_RST[MON_RST_EN_BIT];
            amp_reg     <= OSC_CTRL2_RST[AMP_MODE_BIT];
            guard_reg   <= CONFIG_WRITE_GUARD_RST;
            pll_sel_reg <= PLL_SEL_RST;
            tc_reg      <= TC_TRIM_RST;
            pins_reg    <= 1'b0;
            imask_reg   <= IRQ_RST;
        end else begin
            osc_en_reg  <= osc_en_next;
            mon_en_reg  <= mon_en_next;
            amp_reg     <= amp_next;
            guard_reg   <= guard_next;
            pll_sel_reg <= pll_sel_next;
            tc_reg      <= tc_next;
            pins_reg    <= pins_next;
            imask_reg   <= imask_next;
        end
    end

    // ------------------------------------------------------------
    // status flags and qualification
    // ------------------------------------------------------------
    // qualification counts while the crystal is seen and the pll is locked; an accepted osc_ctrl write restarts it
    always_comb begin
        qcnt_next = qcnt_reg;
        up_next   = up_reg;
        lock_next = pll_locked_in;
        up_evt    = 1'b0;
        loss_evt  = osc_en_reg && up_reg && !osc_clock_seen;
        if (!osc_en_reg || !osc_clock_seen || !pll_locked_in) begin
            qcnt_next = '0;
            up_next   = 1'b0;
        end else if (!up_reg) begin
            if (qcnt_reg == QUAL_CYC[$bits(qcnt_reg)-1:0] - 1'b1) begin
                up_next = 1'b1;
                up_evt  = 1'b1;
            end else begin
                qcnt_next = qcnt_reg + 1'b1;
            end
        end
        if (osc_wr) begin
            lock_next = 1'b0;
            up_next   = 1'b0;
            up_evt    = 1'b0;
            qcnt_next = '0;
        end
        // set beats clear on the sticky interrupt bits
        ist_next = ist_reg;
        if (hit(bus, ADDR_IRQ_STAT))
            ist_next = ist_reg & ~bus.wdata[1:0];
        if (loss_evt)
            ist_next[IRQ_LOSS_BIT] = 1'b1;
        if (up_evt)
            ist_next[IRQ_UP_BIT] = 1'b1;
    end

    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            qcnt_reg <= '0;
            up_reg   <= 1'b0;
            lock_reg <= 1'b0;
            ist_reg  <= IRQ_RST;
        end else begin
            qcnt_reg <= qcnt_next;
            up_reg   <= up_next;
            lock_reg <= lock_next;
            ist_reg  <= ist_next;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_OSC_CTRL:  rdata_next[OSC_EN_BIT] = osc_en_reg;
                ADDR_OSC_CTRL2: rdata_next = {6'h00, mon_en_reg, amp_reg};
                ADDR_CONFIG_WRITE_GUARD:      rdata_next = {7'h00, guard_reg};
                ADDR_CLK_SEL:   rdata_next[PLL_SEL_BIT] = pll_sel_reg;
                ADDR_TRIM_HI:   rdata_next[TC_TRIM_LSB +: TC_TRIM_W] = tc_reg;
                ADDR_STATUS: begin
                    rdata_next[STAT_LOCK_BIT] = lock_reg;
                    rdata_next[STAT_UP_BIT]   = up_reg;
                end
                ADDR_IRQ_STAT:  rdata_next = {6'h00, ist_reg};
                ADDR_IRQ_MASK:  rdata_next = {6'h00, imask_reg};
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata                  = rdata_reg;
    assign osc_ctl.osc_run        = osc_en_reg;
    assign osc_ctl.monitor_on     = osc_en_reg;
    assign osc_ctl.ref_from_osc   = osc_en_reg;
    assign osc_ctl.pins_claimed   = pins_reg;
    assign osc_ctl.amp_full_swing = amp_reg;
    assign osc_src_allowed        = osc_src_req && up_reg;
    assign osc_monitor_reset      = loss_evt && mon_en_reg;
    assign irq                    = |(ist_reg & imask_reg);

    oetc_tc_decode #(.W(TC_TRIM_W)) u_tc (
        .tc_code      (tc_reg),
        .tc_comp_en   (tc_comp_en),
        .tc_positive  (tc_positive),
        .tc_magnitude (tc_magnitude)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!srst_n);

    property p_guarded_write;
        (wr_stb && addr == ADDR_OSC_CTRL && (guard_reg || !pll_sel_reg))
            |=> $stable(osc_en_reg);
    endproperty
    a_guarded_write: assert property (p_guarded_write) else $error("guarded write changed enable");

    property p_write_clears;
        osc_wr |=> (!lock_reg && !up_reg);
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("flags not cleared on write");

    property p_off_ref;
        !osc_en_reg |-> (!osc_ctl.osc_run && !osc_ctl.ref_from_osc && !up_reg);
    endproperty
    a_off_ref: assert property (p_off_ref) else $error("oscillator active while disabled");

    property p_on_monitor;
        osc_en_reg |-> (osc_ctl.monitor_on && osc_ctl.ref_from_osc);
    endproperty
    a_on_monitor: assert property (p_on_monitor) else $error("monitor or reference off");

    property p_pins_sticky;
        pins_reg |=> pins_reg;
    endproperty
    a_pins_sticky: assert property (p_pins_sticky) else $error("crystal pins released");

    property p_mon_reset;
        (osc_en_reg && mon_en_reg && up_reg && !osc_clock_seen) |-> osc_monitor_reset;
    endproperty
    a_mon_reset: assert property (p_mon_reset) else $error("missing monitor reset");

    property p_src_gate;
        osc_src_allowed |-> up_reg;
    endproperty
    a_src_gate: assert property (p_src_gate) else $error("source allowed while unstable");

    property p_key;
        (wr_stb && addr == ADDR_CONFIG_WRITE_GUARD) |=> (guard_reg == ($past(wdata) != CONFIG_WRITE_GUARD_UNLOCK_KEY));
    endproperty
    a_key: assert property (p_key) else $error("guard key decode wrong");

    property p_ctrl2_locked;
        (osc_en_reg && wr_stb && addr == ADDR_OSC_CTRL2) |=> $stable(mon_en_reg);
    endproperty
    a_ctrl2_locked: assert property (p_ctrl2_locked) else $error("ctrl2 changed while enabled");

    c_enable: cover property (osc_wr && wdata[OSC_EN_BIT]);
    c_stable: cover property ($rose(up_reg));
    c_loss:   cover property (osc_monitor_reset);
    c_irq:    cover property ($rose(irq));
endmodule // oetc_ctrl

// File: verif/oetc_osc_model.sv
/*
 * oetc_osc_model: stand-in for the crystal oscillator and the pll behind the control block.
 * Assumes the run request comes from the control block on the same clock.
 */
`timescale 1ns/10ps
module oetc_osc_model #(
    parameter int START_CYC = 5
) (
    input  wire logic clock,
    input  wire logic run,
    input  wire logic lose,
    output logic      osc_clock_seen,
    output logic      pll_locked_in
);
    int cnt = 0;

    // crystal needs a startup time; lose models a dead crystal
    always @(posedge clock) begin
        if (!run || lose) begin
            cnt <= 0;
        end else if (cnt < START_CYC) begin
            cnt <= cnt + 1;
        end
    end

    assign osc_clock_seen = run && !lose && (cnt == START_CYC);
    // on the rc reference the pll stays locked; on the crystal only once it swings
    assign pll_locked_in  = !run || osc_clock_seen;
endmodule // oetc_osc_model

// File: verif/osc_enable_and_tc_trim_ctrl_tb_top.sv
/*
 * osc_enable_and_tc_trim_ctrl_tb_top: self-checking bench for oetc_ctrl.
 * Assumes the package, the design and the oscillator model are compiled first.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module osc_enable_and_tc_trim_ctrl_tb_top;
    import oetc_pkg::*;
    localparam int QC = 8;
    localparam int ST = 5;
    logic          clock = 1'b0;
    logic          rstn = 1'b0;
    logic [3:0]    addr = 4'h0;
    logic [7:0]    wdata = 8'h00;
    logic          wr_stb = 1'b0;
    logic          rd_stb = 1'b0;
    logic          osc_src_req = 1'b0;
    logic          lose = 1'b0;
    logic [7:0]    rdata;
    logic          pll_locked_in;
    logic          osc_clock_seen;
    oetc_osc_ctl_s osc_ctl;
    logic          osc_src_allowed;
    logic          osc_monitor_reset;
    logic          tc_comp_en;
    logic          tc_positive;
    logic [3:0]    tc_magnitude;
    logic          irq;
    int            miscompares = 0;
    int            n_checks = 0;
    int            seed = 86;
    logic [7:0]    d;
    int            cyc = 0;
    int            t0 = 0;

    always #5 clock = ~clock;

    // free-running edge count for qualification timing
    always @(posedge clock) cyc <= cyc + 1;

    oetc_ctrl #(.QUAL_CYC(QC)) oetc_ctrl_inst (
        .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .pll_locked_in(pll_locked_in),
        .osc_clock_seen(osc_clock_seen), .osc_src_req(osc_src_req), .osc_ctl(osc_ctl),
        .osc_src_allowed(osc_src_allowed), .osc_monitor_reset(osc_monitor_reset),
        .tc_comp_en(tc_comp_en), .tc_positive(tc_positive), .tc_magnitude(tc_magnitude),
        .irq(irq));

    oetc_osc_model #(.START_CYC(ST)) oetc_osc_model_inst (
        .clock(clock), .run(osc_ctl.osc_run), .lose(lose),
        .osc_clock_seen(osc_clock_seen), .pll_locked_in(pll_locked_in));

    // source requests wander at random all run long
    always @(posedge clock) osc_src_req <= 1'($random(seed));

    // ----------------------------------------------------------
    // bus tasks and expectations
    // ----------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic src_chk(input logic up);
        repeat (6) begin
            @(negedge clock);
            `CHK("src_allowed", osc_src_req & up, osc_src_allowed)
        end
    endtask

    // bounded poll; flag due lo cycles after t0, seen by a read one or two cycles later
    task automatic wait_up(input int lo);
        int i;
        for (i = 0; i < 40; i++) begin
            rd(ADDR_STATUS);
            if (d[STAT_UP_BIT] === 1'b1) break;
        end
        `CHK("qual_time", 1'b1, (cyc - t0 >= lo + 1) && (cyc - t0 <= lo + 2) && (i < 40))
        if (i == 40) close_out();
    endtask

    function automatic logic [5:0] exp_tc(input logic [4:0] c);
        return {c[3:0] != 4'h0, c[4], c[3:0]};
    endfunction

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        do_reset();
        rd(ADDR_OSC_CTRL);
        `CHK("osc_ctrl", OSC_CTRL_RST, d)
        `CHK("osc_ctl", 5'h00, osc_ctl)
        rd(ADDR_CLK_SEL);
        `CHK("pll_sel", PLL_SEL_RST, d[PLL_SEL_BIT])
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_TRIM_HI, 8'(c << TC_TRIM_LSB));
            `CHK("tc", exp_tc(5'(c)), {tc_comp_en, tc_positive, tc_magnitude})
        end
        // frequency trim lives elsewhere, so the coefficient goes back to nominal
        wr(ADDR_TRIM_HI, 8'h00);
        `CHK("tc_nominal", 1'b0, tc_comp_en)
        d = 8'($random(seed));
        if (d == CONFIG_WRITE_GUARD_UNLOCK_KEY) d = 8'h00;
        wr(ADDR_CONFIG_WRITE_GUARD, d);
        wr(ADDR_OSC_CTRL, 8'h80);
        `CHK("guarded_wr", 5'h00, osc_ctl)
        rd(ADDR_CONFIG_WRITE_GUARD);
        `CHK("guard_set", 1'b1, d[0])
        wr(ADDR_CONFIG_WRITE_GUARD, CONFIG_WRITE_GUARD_UNLOCK_KEY);
        rd(ADDR_CONFIG_WRITE_GUARD);
        `CHK("guard_clr", 1'b0, d[0])
        wr(ADDR_CLK_SEL, 8'h00);
        wr(ADDR_OSC_CTRL, 8'h80);
        `CHK("nopll_wr", 5'h00, osc_ctl)
        wr(ADDR_CLK_SEL, 8'h40);
        wr(ADDR_OSC_CTRL2, 8'h03);
        `CHK("amp_mode", 1'b1, osc_ctl.amp_full_swing)
        wr(ADDR_OSC_CTRL, 8'h80);
        t0 = cyc;
        `CHK("osc_on", 5'h1f, osc_ctl)
        rd(ADDR_STATUS);
        `CHK("flags_clr", 2'h0, d[3:2])
        src_chk(1'b0);
        wait_up(ST + QC);
        src_chk(1'b1);
        // mask bits enable sources; reset leaves all of them masked
        `CHK("irq_masked", 1'b0, irq)
        wr(ADDR_IRQ_MASK, 8'h03);
        `CHK("irq_up", 1'b1, irq)
        wr(ADDR_IRQ_STAT, 8'h01);
        `CHK("irq_w1c", 1'b0, irq)
        // rewrite while running: stable drops and qualification restarts
        wr(ADDR_OSC_CTRL, 8'h80);
        t0 = cyc;
        rd(ADDR_STATUS);
        `CHK("rewr_up_clr", 1'b0, d[STAT_UP_BIT])
        wait_up(QC);
        wr(ADDR_OSC_CTRL2, 8'h00);
        rd(ADDR_OSC_CTRL2);
        `CHK("ctrl2_held", 2'h3, d[1:0])
        // crystal dies while the monitor reset is armed
        @(posedge clock);
        lose <= 1'b1;
        @(negedge clock);
        `CHK("mon_rst", 1'b1, osc_monitor_reset)
        rd(ADDR_IRQ_STAT);
        `CHK("loss_evt", 1'b1, d[IRQ_LOSS_BIT])
        @(posedge clock);
        lose <= 1'b0;
        wr(ADDR_OSC_CTRL, 8'h00);
        `CHK("osc_off", 5'h03, osc_ctl)
        rd(ADDR_STATUS);
        `CHK("up_clr", 1'b0, d[STAT_UP_BIT])
        do_reset();
        `CHK("pins_free", 5'h00, osc_ctl)
        close_out();
    end
endmodule // osc_enable_and_tc_trim_ctrl_tb_top
